// [verif/sw_cpu.sv]
`timescale 1ns/1ns
`default_nettype none
module sw_cpu (
	input  wire logic        i_clk,
	input  wire logic        i_awready,
	input  wire logic        i_wready,
	input  wire logic        i_bvalid,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_arready,
	input  wire logic        i_rvalid,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	output var logic [7:0]   o_awaddr,
	output var logic         o_awvalid,
	output var logic [31:0]  o_wdata,
	output var logic [3:0]   o_wstrb,
	output var logic         o_wvalid,
	output var logic         o_bready,
	output var logic [7:0]   o_araddr,
	output var logic         o_arvalid,
	output var logic         o_rready
);
	logic [1:0] bresp_q;

	// bus idle at time zero
	initial begin
		o_awaddr = 8'h00;
		o_awvalid = 1'b0;
		o_wdata = 32'h0;
		o_wstrb = 4'h0;
		o_wvalid = 1'b0;
		o_bready = 1'b0;
		o_araddr = 8'h00;
		o_arvalid = 1'b0;
		o_rready = 1'b0;
	end

	// one write; each channel dropped only at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		o_awaddr <= a;
		o_wdata <= d;
		o_wstrb <= 4'hf;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		// no local limit: a hung slave is caught by the bench watchdog
		do begin
			@(posedge i_clk);
			if (i_awready) o_awvalid <= 1'b0;
			if (i_wready) o_wvalid <= 1'b0;
		end while (i_bvalid !== 1'b1);
		bresp_q = i_bresp;
		o_bready <= 1'b0;
		// spare edge so a following call never re-drives in the same step
		@(posedge i_clk);
	endtask

	// one read, data taken at the edge that sees rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		o_rready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (i_arready) o_arvalid <= 1'b0;
		end while (i_rvalid !== 1'b1);
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
		@(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// [verif/windowed_service_watchdog_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module windowed_service_watchdog_tb;
	logic        clk, resetn, debug, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, nmi, sysrst, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rd_r;
	int          n_mismatch, checked, cyc, t0;

	windowed_service_watchdog windowed_service_watchdog_i (.i_clk(clk), .i_resetn(resetn),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bvalid(bvalid),
		.o_bresp(bresp), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rvalid(rvalid), .o_rdata(rdata), .o_rresp(rresp),
		.i_rready(rready), .i_debug_mode(debug), .o_watchdog_nmi_request(nmi),
		.o_watchdog_system_reset(sysrst), .o_irq(irq));
	sw_cpu sw_cpu_i (.i_clk(clk), .i_awready(awready), .i_wready(wready), .i_bvalid(bvalid),
		.i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid), .i_rdata(rdata),
		.i_rresp(rresp), .o_awaddr(awaddr), .o_awvalid(awvalid), .o_wdata(wdata),
		.o_wstrb(wstrb), .o_wvalid(wvalid), .o_bready(bready), .o_araddr(araddr),
		.o_arvalid(arvalid), .o_rready(rready));

	// clock and free-running cycle count for latency checks
	always #5 clk = ~clk;
	always @(posedge clk) cyc++;

	task automatic check_eq(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic check_in(input string nm, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] got);
		checked++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("unexpected %s expected %h..%h seen %h", nm, lo, hi, got);
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		sw_cpu_i.rd(a, rd_v, rd_r);
		check_eq(nm, exp, rd_v);
	endtask

	// bounded wait for nmi (sel 0) or system reset (sel 1)
	task automatic wait_hi(input bit sel, input int lim);
		int n;
		n = 0;
		while ((sel ? sysrst : nmi) !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		// a wait that runs out is a failure in its own right
		if (n >= lim) begin
			n_mismatch++;
			$display("unexpected wait timeout expected %0d seen %0d", sel, n);
		end
	endtask

	task automatic restart;
		resetn <= 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
	endtask

	task automatic complete_run;
		$display("mismatches %0d, comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// a hang counts as a mismatch; full run is about 35k cycles
	initial begin
		#500000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		debug = 1'b0;
		restart();
		// reset values and an unmapped address
		rchk("ctrl", wd_pkg::OFF_CTRL, 32'h8);
		rchk("phase", wd_pkg::OFF_PHASE, 32'h100);
		rchk("unmapped", 8'h40, 32'h0);
		check_eq("rresp", 32'(wd_pkg::RESP_SLVERR), 32'(rd_r));
		sw_cpu_i.wr(8'h40, 32'h1);
		check_eq("bresp unmapped", 32'(wd_pkg::RESP_SLVERR), 32'(sw_cpu_i.bresp_q));
		rchk("ctrl kept", wd_pkg::OFF_CTRL, 32'h8);
		// overflow at fast rate from the top reload, then prewarning length
		sw_cpu_i.wr(wd_pkg::OFF_RELOAD, 32'hff);
		sw_cpu_i.wr(wd_pkg::OFF_CTRL, 32'h1);
		sw_cpu_i.wr(wd_pkg::OFF_SERVICE, 32'h0);
		t0 = cyc;
		wait_hi(0, 2000);
		check_in("ovf cycles", 508, 518, cyc - t0);
		t0 = cyc;
		sw_cpu_i.wr(wd_pkg::OFF_SERVICE, 32'h0);
		wait_hi(1, 500);
		check_in("prewarn cycles", 92, 100, cyc - t0);
		rchk("status", wd_pkg::OFF_IRQ_ST, 32'h5);
		check_eq("irq masked", 32'h0, 32'(irq));
		sw_cpu_i.wr(wd_pkg::OFF_IRQ_MSK, 32'h4);
		rchk("mask", wd_pkg::OFF_IRQ_MSK, 32'h4);
		check_eq("irq set", 32'h1, 32'(irq));
		sw_cpu_i.wr(wd_pkg::OFF_IRQ_ST, 32'h5);
		rchk("status clr", wd_pkg::OFF_IRQ_ST, 32'h0);
		check_eq("irq clr", 32'h0, 32'(irq));
		// window off: service accepted low in the count, reload lands in high byte
		restart();
		sw_cpu_i.wr(wd_pkg::OFF_RELOAD, 32'h10);
		sw_cpu_i.wr(wd_pkg::OFF_WINDOW, 32'h80);
		sw_cpu_i.wr(wd_pkg::OFF_CTRL, 32'h1);
		repeat (60) @(posedge clk);
		sw_cpu_i.wr(wd_pkg::OFF_SERVICE, 32'h0);
		check_eq("bresp", 32'(wd_pkg::RESP_OKAY), 32'(sw_cpu_i.bresp_q));
		sw_cpu_i.rd(wd_pkg::OFF_COUNT, rd_v, rd_r);
		check_in("count", 32'h1000, 32'h1008, rd_v);
		rchk("phase run", wd_pkg::OFF_PHASE, 32'h100);
		// window on: the same service is now early and invalid
		sw_cpu_i.wr(wd_pkg::OFF_CTRL, 32'h5);
		sw_cpu_i.wr(wd_pkg::OFF_SERVICE, 32'h0);
		sw_cpu_i.rd(wd_pkg::OFF_PHASE, rd_v, rd_r);
		check_eq("phase inv", 32'h2, 32'(rd_v[10:8]));
		rchk("status inv", wd_pkg::OFF_IRQ_ST, 32'h2);
		check_eq("nmi inv", 32'h0, 32'(nmi));
		// debug freeze, then release
		restart();
		debug <= 1'b1;
		sw_cpu_i.wr(wd_pkg::OFF_CTRL, 32'h9);
		repeat (50) @(posedge clk);
		rchk("count dbg", wd_pkg::OFF_COUNT, 32'h0);
		debug <= 1'b0;
		repeat (20) @(posedge clk);
		sw_cpu_i.rd(wd_pkg::OFF_COUNT, rd_v, rd_r);
		check_in("count run", 32'h8, 32'h14, rd_v);
		// slow rate overflow
		restart();
		sw_cpu_i.wr(wd_pkg::OFF_RELOAD, 32'hff);
		sw_cpu_i.wr(wd_pkg::OFF_CTRL, 32'h3);
		sw_cpu_i.wr(wd_pkg::OFF_SERVICE, 32'h0);
		t0 = cyc;
		wait_hi(0, 40000);
		check_in("slow ovf", 32760, 32900, cyc - t0);
		complete_run();
	end
endmodule
`default_nettype wire

// [verilog/wd_pkg.sv]
`default_nettype none
package wd_pkg;
	// register byte offsets, one aligned word each
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_RELOAD  = 8'h04;
	localparam logic [7:0] OFF_WINDOW  = 8'h08;
	localparam logic [7:0] OFF_SERVICE = 8'h0c;
	localparam logic [7:0] OFF_COUNT   = 8'h10;
	localparam logic [7:0] OFF_PHASE   = 8'h14;
	localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
	localparam logic [7:0] OFF_IRQ_MSK = 8'h1c;

	// control field positions
	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_RATE_BIT = 1;
	localparam int CTRL_WIN_BIT  = 2;
	localparam int CTRL_DBG_BIT  = 3;

	// sticky event positions, same layout in status and mask
	localparam int EV_OVF_BIT = 0;
	localparam int EV_INV_BIT = 1;
	localparam int EV_RST_BIT = 2;

	// reset values
	localparam logic [3:0] CTRL_RST   = 4'h8;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [7:0] WINDOW_RST = 8'h00;
	localparam logic [2:0] MASK_RST   = 3'h0;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	// timing counts: last prescaler value per rate and prewarning length
	localparam logic [6:0] PRE_FAST_LAST = 7'h01;
	localparam logic [6:0] PRE_SLOW_LAST = 7'h7f;
	localparam logic [5:0] PW_LAST       = 6'h2f;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PH_RUN     = 3'h1,
		PH_PREWARN = 3'h2,
		PH_RESET   = 3'h4
	} wd_phase_t;
endpackage
`default_nettype wire

// [verilog/windowed_service_watchdog.sv]
// Function
// - 16-bit up-counter advances every 2 clocks, or every 128 when rate selected.
// - counter is one 16-bit register; service loads upper byte with reload, clears lower.
// - after service counting resumes from reload byte times 256.
// - overflow without service raises watchdog NMI request and enters prewarning.
// - prewarning lasts 30 hex count ticks, then system reset request asserts.
// - with window on, service below window byte times 256 is invalid: prewarn, no NMI.
// - window check applies only when enabled; otherwise service accepted anywhere.
// - in debug mode the watchdog is suspended by default and holds its count.
`timescale 1ns/1ns
`default_nettype none
module windowed_service_watchdog (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic             o_bvalid,
	output logic [1:0]       o_bresp,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic             o_rvalid,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	input  wire logic        i_rready,
	input  wire logic        i_debug_mode,
	output logic             o_watchdog_nmi_request,
	output logic             o_watchdog_system_reset,
	output logic             o_irq
);
	typedef struct packed {
		wd_pkg::wd_phase_t phase;
		logic [15:0]       cnt;
		logic [6:0]        pre;
		logic [5:0]        pw;
		logic [3:0]        ctrl;
		logic [7:0]        reload;
		logic [7:0]        window;
		logic [2:0]        status;
		logic [2:0]        mask;
		logic              nmi;
		logic              sysrst;
		logic              irq;
		logic              awready;
		logic              wready;
		logic              aw_got;
		logic              w_got;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} wd_regs_t;

	localparam wd_regs_t RST_S = '{
		phase:   wd_pkg::PH_RUN,
		cnt:     wd_pkg::COUNT_RST,
		ctrl:    wd_pkg::CTRL_RST,
		reload:  wd_pkg::RELOAD_RST,
		window:  wd_pkg::WINDOW_RST,
		mask:    wd_pkg::MASK_RST,
		awready: 1'b1,
		wready:  1'b1,
		arready: 1'b1,
		default: '0
	};

	wd_regs_t   s_ff;
	wd_regs_t   nxt_s;
	logic [6:0] pre_last;
	logic       active;
	logic       tick;
	logic       wr_go;
	logic       svc;
	logic       svc_bad;
	logic [2:0] ev_set;
	logic [2:0] ev_clr;

	// all state in one register; async reset loads constants only
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_ff <= RST_S;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// next-state logic: bus slave, counter, phase machine, interrupt
	always_comb begin
		nxt_s = s_ff;
		ev_set = 3'h0;
		ev_clr = 3'h0;
		pre_last = s_ff.ctrl[wd_pkg::CTRL_RATE_BIT] ? wd_pkg::PRE_SLOW_LAST
			: wd_pkg::PRE_FAST_LAST;
		// debug freezes prescaler, counter and prewarning alike
		active = s_ff.ctrl[wd_pkg::CTRL_RUN_BIT]
			& ~(i_debug_mode & s_ff.ctrl[wd_pkg::CTRL_DBG_BIT]);
		tick = active & (s_ff.pre == pre_last);
		wr_go = s_ff.aw_got & s_ff.w_got & ~s_ff.bvalid;
		svc = wr_go & (s_ff.awaddr == wd_pkg::OFF_SERVICE);
		svc_bad = s_ff.ctrl[wd_pkg::CTRL_WIN_BIT]
			& (s_ff.cnt < {s_ff.window, 8'h00});

		// write address and data are caught independently, in either order
		if (i_awvalid && s_ff.awready) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.awaddr = i_awaddr;
		end
		if (i_wvalid && s_ff.wready) begin
			nxt_s.w_got = 1'b1;
			nxt_s.wdata = i_wdata;
			nxt_s.wstrb = i_wstrb;
		end
		if (s_ff.bvalid && i_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (wr_go) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = wd_pkg::RESP_OKAY;
			// every field sits in byte lane 0, so only that strobe matters
			case (s_ff.awaddr)
				wd_pkg::OFF_CTRL: begin
					if (s_ff.wstrb[0]) nxt_s.ctrl = s_ff.wdata[3:0];
				end
				wd_pkg::OFF_RELOAD: begin
					if (s_ff.wstrb[0]) nxt_s.reload = s_ff.wdata[7:0];
				end
				wd_pkg::OFF_WINDOW: begin
					if (s_ff.wstrb[0]) nxt_s.window = s_ff.wdata[7:0];
				end
				wd_pkg::OFF_IRQ_ST: begin
					if (s_ff.wstrb[0]) ev_clr = s_ff.wdata[2:0];
				end
				wd_pkg::OFF_IRQ_MSK: begin
					if (s_ff.wstrb[0]) nxt_s.mask = s_ff.wdata[2:0];
				end
				wd_pkg::OFF_SERVICE, wd_pkg::OFF_COUNT, wd_pkg::OFF_PHASE: begin
					nxt_s.bresp = wd_pkg::RESP_OKAY;
				end
				default: begin
					nxt_s.bresp = wd_pkg::RESP_SLVERR;
				end
			endcase
		end
		// one write in flight: ready drops until the response is taken
		nxt_s.awready = ~nxt_s.aw_got & ~nxt_s.bvalid;
		nxt_s.wready = ~nxt_s.w_got & ~nxt_s.bvalid;

		// read channel: data registered at the address handshake
		if (s_ff.rvalid && i_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (i_arvalid && s_ff.arready) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = wd_pkg::RESP_OKAY;
			case (i_araddr)
				wd_pkg::OFF_CTRL:    nxt_s.rdata = {28'h0000000, s_ff.ctrl};
				wd_pkg::OFF_RELOAD:  nxt_s.rdata = {24'h000000, s_ff.reload};
				wd_pkg::OFF_WINDOW:  nxt_s.rdata = {24'h000000, s_ff.window};
				wd_pkg::OFF_SERVICE: nxt_s.rdata = 32'h00000000;
				wd_pkg::OFF_COUNT:   nxt_s.rdata = {16'h0000, s_ff.cnt};
				wd_pkg::OFF_PHASE:   nxt_s.rdata = {21'h000000, s_ff.phase, 2'h0, s_ff.pw};
				wd_pkg::OFF_IRQ_ST:  nxt_s.rdata = {29'h00000000, s_ff.status};
				wd_pkg::OFF_IRQ_MSK: nxt_s.rdata = {29'h00000000, s_ff.mask};
				default: begin
					nxt_s.rdata = 32'h00000000;
					nxt_s.rresp = wd_pkg::RESP_SLVERR;
				end
			endcase
		end
		nxt_s.arready = ~nxt_s.rvalid;

		// prescaler divides the clock down to the count rate
		if (active) begin
			nxt_s.pre = tick ? 7'h00 : s_ff.pre + 7'h01;
		end

		case (s_ff.phase)
			wd_pkg::PH_RUN: begin
				if (tick) begin
					nxt_s.cnt = s_ff.cnt + 16'h0001;
				end
				// a service in the same cycle as overflow still counts as on time
				if (svc && svc_bad) begin
					nxt_s.phase = wd_pkg::PH_PREWARN;
					nxt_s.pw = 6'h00;
					ev_set[wd_pkg::EV_INV_BIT] = 1'b1;
				end else if (svc) begin
					nxt_s.cnt = {s_ff.reload, 8'h00};
					nxt_s.pre = 7'h00;
				end else if (tick && s_ff.cnt == 16'hffff) begin
					nxt_s.phase = wd_pkg::PH_PREWARN;
					nxt_s.nmi = 1'b1;
					nxt_s.pw = 6'h00;
					ev_set[wd_pkg::EV_OVF_BIT] = 1'b1;
				end
			end
			wd_pkg::PH_PREWARN: begin
				// service writes still answer on the bus but change nothing here
				if (tick && s_ff.pw == wd_pkg::PW_LAST) begin
					nxt_s.phase = wd_pkg::PH_RESET;
					nxt_s.sysrst = 1'b1;
					ev_set[wd_pkg::EV_RST_BIT] = 1'b1;
				end else if (tick) begin
					nxt_s.pw = s_ff.pw + 6'h01;
				end
			end
			wd_pkg::PH_RESET: begin
				// reset request holds until the system reset reaches this block
				nxt_s.sysrst = 1'b1;
			end
			default: begin
				nxt_s.phase = wd_pkg::PH_RUN;
			end
		endcase

		// set beats clear so an event in the clearing cycle is kept
		nxt_s.status = (s_ff.status & ~ev_clr) | ev_set;
		nxt_s.irq = |(nxt_s.status & nxt_s.mask);
	end

	assign o_awready = s_ff.awready;
	assign o_wready = s_ff.wready;
	assign o_bvalid = s_ff.bvalid;
	assign o_bresp = s_ff.bresp;
	assign o_arready = s_ff.arready;
	assign o_rvalid = s_ff.rvalid;
	assign o_rdata = s_ff.rdata;
	assign o_rresp = s_ff.rresp;
	assign o_watchdog_nmi_request = s_ff.nmi;
	assign o_watchdog_system_reset = s_ff.sysrst;
	assign o_irq = s_ff.irq;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_good_service;
		svc && !svc_bad && s_ff.phase == wd_pkg::PH_RUN;
	endsequence

	sequence s_overflow;
		tick && s_ff.cnt == 16'hffff && !svc && s_ff.phase == wd_pkg::PH_RUN;
	endsequence

	chk_count_step: assert property (
		s_ff.phase == wd_pkg::PH_RUN && !svc && s_ff.cnt != 16'hffff
		&& s_ff.pre == pre_last && active
		|=> s_ff.cnt == $past(s_ff.cnt) + 16'h0001)
		else $error("count did not step at prescaler end");

	chk_rate_hold: assert property (
		active && s_ff.pre != pre_last && !svc |=> $stable(s_ff.cnt))
		else $error("count moved between ticks");

	chk_service_load: assert property (
		s_good_service |=> s_ff.cnt == {$past(s_ff.reload), 8'h00} && s_ff.pre == 7'h00)
		else $error("service did not reload the counter");

	chk_overflow_nmi: assert property (
		s_overflow |=> s_ff.phase == wd_pkg::PH_PREWARN ##1 o_watchdog_nmi_request)
		else $error("overflow did not raise nmi and prewarning");

	chk_prewarn_end: assert property (
		s_ff.phase == wd_pkg::PH_PREWARN && tick && s_ff.pw == wd_pkg::PW_LAST
		|=> ##1 o_watchdog_system_reset)
		else $error("reset not requested after prewarning");

	chk_reset_cause: assert property (
		$rose(s_ff.sysrst) |-> $past(s_ff.pw) == wd_pkg::PW_LAST && $past(tick))
		else $error("reset requested before prewarning ended");

	chk_window_invalid: assert property (
		svc && svc_bad && s_ff.phase == wd_pkg::PH_RUN
		|=> s_ff.phase == wd_pkg::PH_PREWARN && !s_ff.nmi)
		else $error("window violation not handled without nmi");

	chk_window_off: assert property (
		svc && !s_ff.ctrl[wd_pkg::CTRL_WIN_BIT] && s_ff.phase == wd_pkg::PH_RUN
		|=> s_ff.phase == wd_pkg::PH_RUN)
		else $error("service refused with window check off");

	chk_debug_freeze: assert property (
		i_debug_mode && s_ff.ctrl[wd_pkg::CTRL_DBG_BIT] && !svc
		|=> $stable(s_ff.cnt) && $stable(s_ff.pw))
		else $error("watchdog moved while suspended in debug");

	chk_prewarn_locked: assert property (
		s_ff.phase == wd_pkg::PH_PREWARN && svc |=> s_ff.phase != wd_pkg::PH_RUN)
		else $error("service cancelled a pending reset");
endmodule
`default_nettype wire
